// [design/vsel_pkg.sv]
// vsel_pkg: constants for the video input select and battery short block.
// assumes: register port decoded by the serial host port upstream.
package vsel_pkg;

  // ---------------------------------------------------------------
  // register offsets (user sub map)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_INPUT_FORMAT = 8'h00;
  localparam logic [7:0] ADDR_SENSE_A_CTRL = 8'h5D;
  localparam logic [7:0] ADDR_SENSE_B_CTRL = 8'h5E;
  localparam logic [7:0] ADDR_SHORT_STATUS = 8'h5F;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int FMT_MSB = 4;  // input_format_code [4:0]
  localparam int OFF_BIT = 6;  // comparator power down
  localparam int THR_MSB = 4;  // threshold code [4:2]
  localparam int THR_LSB = 2;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [4:0] FORMAT_RESET = 5'h00;
  localparam logic OFF_RESET = 1'b1;
  localparam logic [2:0] THRESHOLD_RESET = 3'h3;

  // video format classes steered to the decoder core
  typedef enum logic [2:0] {
    VSEL_FMT_CVBS,
    VSEL_FMT_YC,
    VSEL_FMT_YPBPR,
    VSEL_FMT_DIFF,
    VSEL_FMT_NONE
  } vsel_format_e;

endpackage

// [design/vsel_top.sv]
// vsel_top: analog input routing control and battery short diagnostics.
// assumes: host port delivers one-cycle read/write strobes on ref_clk;
// comparator outputs are asynchronous to ref_clk.
//
// Function
// (R1) five bit format code at 0x00[4:0]
// (R2) unused analog inputs are powered down
// (R3) composite codes route to their single input
// (R4) luma/chroma codes route to two inputs
// (R5) component code uses inputs one to three
// (R6) differential codes route positive and negative legs
// (R7) host never writes reserved format codes
// (R8) comparator above threshold means battery short
// (R9) battery short drives active low interrupt
// (R10) status shows which sense pin tripped
// (R11) diagnostics disabled after reset
// (R12) 0x5D bit 6 powers down pin a
// (R13) 0x5D[4:2] pin a threshold, default 011
// (R14) host powers up before trusting threshold
// (R15) 0x5E bit 6 powers down pin b
// (R16) 0x5E[4:2] pin b threshold, default 011
// (R17) sticky flags hold interrupt until cleared
// (R18) comparator outputs pass two stage synchroniser
module vsel_top #(
  parameter bit SIX_INPUTS = 1'b1  // 1: six-input variant, 0: four-input
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,        // register offset
  input wire logic [7:0] reg_wdata,       // write data
  input wire logic reg_write,             // one-cycle write strobe
  input wire logic reg_read,              // one-cycle read strobe
  output logic [7:0] reg_rdata,           // read data, valid next cycle
  input wire logic sense_a_compare,       // async comparator, pin a
  input wire logic sense_b_compare,       // async comparator, pin b
  output logic [5:0] analog_input_power,  // 1 = input channel powered
  output logic [2:0] video_format,        // vsel_format_e value
  output logic format_reserved,           // selected code is reserved
  output logic sense_a_comparator_off,
  output logic [2:0] sense_a_threshold_code,
  output logic sense_b_comparator_off,
  output logic [2:0] sense_b_threshold_code,
  output logic interrupt_request_n
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [4:0] input_format_code, next_input_format_code;  // format code
  logic next_a_off, next_b_off;
  logic [2:0] next_a_thr, next_b_thr;
  logic [1:0] short_flag, next_short_flag;  // battery_short, bit0 = pin a
  logic [1:0] sync_first, sync_second;  // first stage, settled levels
  logic [7:0] next_reg_rdata;
  logic [5:0] next_power;
  logic [2:0] next_format;
  logic next_reserved, next_irq_n;
  logic [1:0] pin_armed;  // comparator powered up per pin
  logic wr_fmt, wr_a, wr_b, wr_stat;  // decoded write strobes

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // decode and next values of the control registers
  always_comb
  begin
    wr_fmt = reg_write && (reg_addr == vsel_pkg::ADDR_INPUT_FORMAT);
    wr_a = reg_write && (reg_addr == vsel_pkg::ADDR_SENSE_A_CTRL);
    wr_b = reg_write && (reg_addr == vsel_pkg::ADDR_SENSE_B_CTRL);
    wr_stat = reg_write && (reg_addr == vsel_pkg::ADDR_SHORT_STATUS);
    next_input_format_code = input_format_code;
    next_a_off = sense_a_comparator_off;
    next_a_thr = sense_a_threshold_code;
    next_b_off = sense_b_comparator_off;
    next_b_thr = sense_b_threshold_code;
    if (wr_fmt)
    begin
      // only the low five bits are stored
      next_input_format_code = reg_wdata[vsel_pkg::FMT_MSB:0];  // [R1]
    end
    if (wr_a)
    begin
      next_a_off = reg_wdata[vsel_pkg::OFF_BIT];  // [R12]
      next_a_thr = reg_wdata[vsel_pkg::THR_MSB:vsel_pkg::THR_LSB];  // [R13]
    end
    if (wr_b)
    begin
      next_b_off = reg_wdata[vsel_pkg::OFF_BIT];  // [R15]
      next_b_thr = reg_wdata[vsel_pkg::THR_MSB:vsel_pkg::THR_LSB];  // [R16]
    end
  end

  // control register storage; comparators start powered down
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      input_format_code <= vsel_pkg::FORMAT_RESET;
      sense_a_comparator_off <= vsel_pkg::OFF_RESET;  // [R11] [R12]
      sense_a_threshold_code <= vsel_pkg::THRESHOLD_RESET;  // [R13]
      sense_b_comparator_off <= vsel_pkg::OFF_RESET;  // [R11] [R15]
      sense_b_threshold_code <= vsel_pkg::THRESHOLD_RESET;  // [R16]
    end
    else
    begin
      input_format_code <= next_input_format_code;
      sense_a_comparator_off <= next_a_off;
      sense_a_threshold_code <= next_a_thr;
      sense_b_comparator_off <= next_b_off;
      sense_b_threshold_code <= next_b_thr;
    end
  end

  // ---------------------------------------------------------------
  // input routing
  // ---------------------------------------------------------------
  // map format code to powered channels and format class
  always_comb
  begin
    next_power = 6'h00;
    next_format = vsel_pkg::VSEL_FMT_NONE;
    // unlisted and variant-reserved codes leave every channel off
    case (input_format_code)
      5'h00:
      begin
        next_power = 6'h01;  // [R2] [R3]
        next_format = vsel_pkg::VSEL_FMT_CVBS;
      end
      5'h01:
      begin
        next_power = 6'h02;  // [R3]
        next_format = vsel_pkg::VSEL_FMT_CVBS;
      end
      5'h02, 5'h03:
      begin
        // input 3 or 4; reserved on the four-input part
        next_power = (input_format_code[0]) ? 6'h08 : 6'h04;  // [R3]
        next_power = SIX_INPUTS ? next_power : 6'h00;
        next_format = SIX_INPUTS ? vsel_pkg::VSEL_FMT_CVBS
                                 : vsel_pkg::VSEL_FMT_NONE;
      end
      5'h06, 5'h07:
      begin
        // inputs 3/4 on four-input part, 5/6 on six-input part
        next_power = (input_format_code[0]) ? 6'h08 : 6'h04;  // [R3]
        next_power = SIX_INPUTS ? (next_power << 2) : next_power;
        next_format = vsel_pkg::VSEL_FMT_CVBS;
      end
      5'h08:
      begin
        next_power = 6'h03;  // [R4]
        next_format = vsel_pkg::VSEL_FMT_YC;
      end
      5'h09:
      begin
        next_power = SIX_INPUTS ? 6'h0C : 6'h00;  // [R4]
        next_format = SIX_INPUTS ? vsel_pkg::VSEL_FMT_YC
                                 : vsel_pkg::VSEL_FMT_NONE;
      end
      5'h0B:
      begin
        next_power = SIX_INPUTS ? 6'h30 : 6'h0C;  // [R4]
        next_format = vsel_pkg::VSEL_FMT_YC;
      end
      5'h0C:
      begin
        next_power = SIX_INPUTS ? 6'h07 : 6'h00;  // [R5]
        next_format = SIX_INPUTS ? vsel_pkg::VSEL_FMT_YPBPR
                                 : vsel_pkg::VSEL_FMT_NONE;
      end
      5'h0E:
      begin
        next_power = 6'h03;  // [R6]
        next_format = vsel_pkg::VSEL_FMT_DIFF;
      end
      5'h0F:
      begin
        next_power = SIX_INPUTS ? 6'h0C : 6'h00;  // [R6]
        next_format = SIX_INPUTS ? vsel_pkg::VSEL_FMT_DIFF
                                 : vsel_pkg::VSEL_FMT_NONE;
      end
      5'h11:
      begin
        next_power = SIX_INPUTS ? 6'h30 : 6'h0C;  // [R6]
        next_format = vsel_pkg::VSEL_FMT_DIFF;
      end
      default:
      begin
        next_power = 6'h00;  // [R7]
        next_format = vsel_pkg::VSEL_FMT_NONE;
      end
    endcase
    next_reserved = (next_format == vsel_pkg::VSEL_FMT_NONE);  // [R7]
  end

  // routing outputs registered
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      analog_input_power <= 6'h00;
      video_format <= vsel_pkg::VSEL_FMT_NONE;
      format_reserved <= 1'b0;
    end
    else
    begin
      analog_input_power <= next_power;
      video_format <= next_format;
      format_reserved <= next_reserved;
    end
  end

  // ---------------------------------------------------------------
  // battery short diagnostics
  // ---------------------------------------------------------------
  // sticky flags: set wins over a write-one clear in the same cycle
  always_comb
  begin
    pin_armed = {~sense_b_comparator_off, ~sense_a_comparator_off};
    next_short_flag = short_flag;
    if (wr_stat)
    begin
      next_short_flag = short_flag & ~reg_wdata[1:0];  // [R17]
    end
    // exceedance while powered counts as a battery_short
    next_short_flag = next_short_flag | (sync_second & pin_armed);  // [R8]
    next_irq_n = ~(|next_short_flag);  // [R9]
  end

  // synchroniser and flag storage
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      sync_first <= 2'h0;
      sync_second <= 2'h0;
      short_flag <= 2'h0;
      interrupt_request_n <= 1'b1;
    end
    else
    begin
      sync_first <= {sense_b_compare, sense_a_compare};  // [R18]
      sync_second <= sync_first;  // [R18]
      short_flag <= next_short_flag;  // [R17]
      interrupt_request_n <= next_irq_n;  // [R9]
    end
  end

  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------
  // read mux; unmapped offsets read zero
  always_comb
  begin
    next_reg_rdata = reg_rdata;
    if (reg_read)
    begin
      case (reg_addr)
        vsel_pkg::ADDR_INPUT_FORMAT:
        begin
          next_reg_rdata = {3'h0, input_format_code};
        end
        vsel_pkg::ADDR_SENSE_A_CTRL:
        begin
          next_reg_rdata = {1'b0, sense_a_comparator_off, 1'b0,
                            sense_a_threshold_code, 2'h0};
        end
        vsel_pkg::ADDR_SENSE_B_CTRL:
        begin
          next_reg_rdata = {1'b0, sense_b_comparator_off, 1'b0,
                            sense_b_threshold_code, 2'h0};
        end
        vsel_pkg::ADDR_SHORT_STATUS:
        begin
          next_reg_rdata = {6'h00, short_flag};  // [R10]
        end
        default:
        begin
          next_reg_rdata = 8'h00;
        end
      endcase
    end
  end

  // read data register
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      reg_rdata <= 8'h00;
    end
    else
    begin
      reg_rdata <= next_reg_rdata;
    end
  end

endmodule // vsel_top

// [testbench/vsel_properties.sv]
// vsel_properties: port level checks for vsel_top.
// assumes: bound to vsel_top, one clock, synchronous active low reset.
module vsel_properties (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic sense_a_compare,
  input wire logic sense_b_compare,
  input wire logic [5:0] analog_input_power,
  input wire logic [2:0] video_format,
  input wire logic format_reserved,
  input wire logic sense_a_comparator_off,
  input wire logic [2:0] sense_a_threshold_code,
  input wire logic sense_b_comparator_off,
  input wire logic [2:0] sense_b_threshold_code,
  input wire logic interrupt_request_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  reset_vals_a: assert property (
    $rose(reset_n) |-> sense_a_comparator_off && sense_b_comparator_off
    && sense_a_threshold_code == 3'h3 && sense_b_threshold_code == 3'h3
    && interrupt_request_n) else $error("bad reset state");
  ctrl_a_write_a: assert property (
    reg_write && reg_addr == 8'h5D |=> sense_a_comparator_off ==
    $past(reg_wdata[6]) && sense_a_threshold_code == $past(reg_wdata[4:2]))
    else $error("pin a control not stored");
  ctrl_b_read_a: assert property (
    reg_read && reg_addr == 8'h5E |=> reg_rdata == {1'h0,
    $past(sense_b_comparator_off), 1'h0, $past(sense_b_threshold_code),
    2'h0}) else $error("pin b control readback wrong");
  yc_route_a: assert property (
    reg_write && reg_addr == 8'h00 && reg_wdata[4:0] == 5'h08 |=> ##1
    analog_input_power == 6'h03 && video_format == 3'h1)
    else $error("luma chroma routing wrong");
  cvbs_single_a: assert property (
    video_format == 3'h0 |-> $countones(analog_input_power) == 1)
    else $error("composite powers more than one input");
  a_trip_a: assert property (
    (sense_a_compare && !sense_a_comparator_off)[*4] |=>
    !interrupt_request_n) else $error("pin a event missed");
  b_trip_a: assert property (
    (sense_b_compare && !sense_b_comparator_off)[*4] |=>
    !interrupt_request_n) else $error("pin b event missed");
  irq_sticky_a: assert property (
    !interrupt_request_n && !reg_write |=> !interrupt_request_n)
    else $error("interrupt dropped without clear");
endmodule // vsel_properties

bind vsel_top vsel_properties u_vsel_properties (.*);

// [testbench/vsel_sense_model.sv]
// vsel_sense_model: divided connector voltages and both pin slicers.
// assumes: voltages in millivolts from the bench, levels from the block.
module vsel_sense_model (
  input wire logic [11:0] mv_a,
  input wire logic [11:0] mv_b,
  input wire logic sense_a_comparator_off,
  input wire logic [2:0] sense_a_threshold_code,
  input wire logic sense_b_comparator_off,
  input wire logic [2:0] sense_b_threshold_code,
  output logic sense_a_compare,
  output logic sense_b_compare
);
  timeunit 1ns;
  timeprecision 1ns;
  // powered down slicer has no valid level: any nonzero voltage trips it
  assign sense_a_compare = sense_a_comparator_off ? (mv_a != 0) :
    (mv_a > 75 + 150 * sense_a_threshold_code);
  assign sense_b_compare = sense_b_comparator_off ? (mv_b != 0) :
    (mv_b > 75 + 150 * sense_b_threshold_code);
endmodule // vsel_sense_model

// [testbench/vsel_top_bench.sv]
// vsel_top_bench: register sequences against vsel_top, six-input variant, with the four-input variant checked for routing.
// assumes: vsel_sense_model stands in for the sense network.
module vsel_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [11:0] mv_a = 12'h000;
  logic [11:0] mv_b = 12'h000;
  logic [7:0] reg_rdata;
  logic sense_a_compare, sense_b_compare, format_reserved;
  logic sense_a_comparator_off, sense_b_comparator_off;
  logic interrupt_request_n;
  logic [5:0] analog_input_power;
  logic [2:0] video_format, sense_a_threshold_code, sense_b_threshold_code;
  // routing outputs of the four-input variant
  logic [5:0] four_power;
  logic [2:0] four_format;
  logic four_reserved;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  // 20 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  vsel_top u_vsel_top (.*);
  vsel_sense_model u_vsel_sense_model (.*);
  // four-input variant sees the same writes, for its own routing table
  vsel_top #(.SIX_INPUTS(1'b0)) u_vsel_top_four (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(),
    .sense_a_compare(sense_a_compare),
    .sense_b_compare(sense_b_compare),
    .analog_input_power(four_power),
    .video_format(four_format),
    .format_reserved(four_reserved),
    .sense_a_comparator_off(),
    .sense_a_threshold_code(),
    .sense_b_comparator_off(),
    .sense_b_threshold_code(),
    .interrupt_request_n()
  );
  // hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (bad_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one-cycle register strobes, driven 5 ns after the edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) #5;
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(posedge ref_clk) #5;
    reg_write = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk) #5;
    reg_addr = a;
    reg_read = 1'b1;
    @(posedge ref_clk) #5;
    reg_read = 1'b0;
    check({2'h0, reg_rdata}, {2'h0, exp});
  endtask
  // set a pin voltage, let the sync and flag settle, look at the interrupt
  task automatic trip(input int p, input int mv, input logic exp_n);
    @(posedge ref_clk) #5;
    if (p == 0)
      mv_a = 12'(mv);
    else
      mv_b = 12'(mv);
    repeat (5) @(posedge ref_clk);
    #5;
    check(10'(interrupt_request_n), 10'(exp_n));
  endtask
  // expected {reserved, format, power}, six- or four-input variant
  function automatic logic [9:0] route(input logic [4:0] c, input bit six);
    case (c)
      5'h00: return 10'h001;
      5'h01: return 10'h002;
      5'h02: return six ? 10'h004 : 10'h300;
      5'h03: return six ? 10'h008 : 10'h300;
      5'h06: return six ? 10'h010 : 10'h004;
      5'h07: return six ? 10'h020 : 10'h008;
      5'h08: return 10'h043;
      5'h09: return six ? 10'h04C : 10'h300;
      5'h0B: return six ? 10'h070 : 10'h04C;
      5'h0C: return six ? 10'h087 : 10'h300;
      5'h0E: return 10'h0C3;
      5'h0F: return six ? 10'h0CC : 10'h300;
      5'h11: return six ? 10'h0F0 : 10'h0CC;
      default: return 10'h300;
    endcase
  endfunction
  // main sequence
  initial
  begin
    repeat (8) @(posedge ref_clk);
    #5;
    reset_n = 1'b1;
    rd(8'h00, 8'h00);
    rd(8'h5D, 8'h4C);
    rd(8'h5E, 8'h4C);
    rd(8'h10, 8'h00);
    // powered down pins ignore a short
    trip(0, 1200, 1'b1);
    trip(1, 1200, 1'b1);
    trip(0, 0, 1'b1);
    trip(1, 0, 1'b1);
    // every format code the host may write, upper bits set to prove they are dropped
    for (int c = 0; c < 32; c++)
    begin
      // the host never writes the codes reserved on every variant
      if (c == 4 || c == 5 || c == 10 || c == 13 || c == 16 || c > 17)
        continue;
      wr(8'h00, 8'(c) | 8'hE0);
      // routing outputs follow one cycle after the stored code
      @(posedge ref_clk) #5;
      check({format_reserved, video_format, analog_input_power},
        route(5'(c), 1'b1));
      check({four_reserved, four_format, four_power},
        route(5'(c), 1'b0));
      rd(8'h00, 8'(c));
    end
    wr(8'h5D, 8'hFF);
    rd(8'h5D, 8'h5C);
    // every slice level on both pins, at and just over the level
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 8; c++)
      begin
        wr(p ? 8'h5E : 8'h5D, 8'(c << 2));
        trip(p, 75 + 150 * c, 1'b1);
        trip(p, 76 + 150 * c, 1'b0);
        rd(8'h5F, p ? 8'h02 : 8'h01);
        trip(p, 0, 1'b0);
        wr(8'h5F, 8'h03);
        trip(p, 0, 1'b1);
      end
    // clear while the short persists: flag sets again
    trip(0, 1200, 1'b0);
    wr(8'h5F, 8'h01);
    // set wins: the interrupt never lifts on the clearing edge
    check(10'(interrupt_request_n), 10'h000);
    trip(0, 1200, 1'b0);
    print_verdict();
  end
endmodule // vsel_top_bench
